// ---- design/i2c_ctl_pkg.sv ----
// constants and types of the side-1 bus controller
package i2c_ctl_pkg;

   // ***********************************************
   // clock and signalling rates
   // ***********************************************
   localparam int unsigned CLK_HZ      = 100_000_000;
   localparam int unsigned RATE_STD_BPS  = 100_000;
   localparam int unsigned RATE_FAST_BPS = 400_000;
   localparam int unsigned RATE_HI_BPS   = 1_700_000;
   // quarter bit time, rounded up; a bit spans only three of them, so the rate runs about 4/3 above the figure
   localparam int unsigned QTR_STD  =
      (CLK_HZ + 4 * RATE_STD_BPS - 1) / (4 * RATE_STD_BPS);
   localparam int unsigned QTR_FAST =
      (CLK_HZ + 4 * RATE_FAST_BPS - 1) / (4 * RATE_FAST_BPS);
   localparam int unsigned QTR_HI   =
      (CLK_HZ + 4 * RATE_HI_BPS - 1) / (4 * RATE_HI_BPS);
   localparam int unsigned CNT_W    = 16;

   // ***********************************************
   // framing figures
   // ***********************************************
   localparam int unsigned ADDR_W   = 7;
   localparam int unsigned BYTE_W   = 8;
   localparam logic [3:0]  ACK_BIT  = 4'h8;
   localparam logic        DIR_WRITE = 1'b0;
   localparam logic        DIR_READ  = 1'b1;
   localparam logic [1:0]  PH_FIRST = 2'h0;
   localparam logic [1:0]  PH_MID   = 2'h1;
   localparam logic [1:0]  PH_LAST  = 2'h2;

   // ***********************************************
   // speed select, commands and sequencer states
   // ***********************************************
   typedef enum logic [1:0] {
      SPEED_STD  = 2'h0,
      SPEED_FAST = 2'h1,
      SPEED_HI   = 2'h2
   } speed_type;

   typedef enum logic [1:0] {
      CMD_START = 2'h0,
      CMD_WRITE = 2'h1,
      CMD_READ  = 2'h2,
      CMD_STOP  = 2'h3
   } cmd_type;

   typedef enum logic [4:0] {
      ST_IDLE  = 5'b00001,
      ST_START = 5'b00010,
      ST_BYTE  = 5'b00100,
      ST_HOLD  = 5'b01000,
      ST_STOP  = 5'b10000
   } state_type;

endpackage : i2c_ctl_pkg

// ---- design/i2c_side1_ctl.sv ----
// side-1 bus controller driving the local wires of the isolating repeater
`timescale 1ns/1ns
// Functional notes
// - every wire needs a pull-up, never floats
// - data changes only while clock is low
// - start falls, stop rises, with clock high
// - start followed by 7-bit address, direction
// - receiver acknowledges low during 9th clock high
// - address and data bytes sent MSB first
// - reader acknowledges all bytes except the last
// - end with stop or repeated start
// - rates 100 kbps, 400 kbps, 1.7 Mbps; here a bit spans three quarter bit times, so rates run about 4/3 above
// - local side serves one single controller node

module i2c_side1_ctl (
   // clock and reset
   input  wire logic                       mclk_i,
   input  wire logic                       rst_i,
   // user command port
   input  wire logic                       cmd_valid_i,
   output logic                            cmd_ready_o,
   input  wire i2c_ctl_pkg::cmd_type       cmd_i,
   input  wire i2c_ctl_pkg::speed_type     speed_i,
   input  wire logic [6:0]                 addr_i,
   input  wire logic                       dir_i,
   input  wire logic [7:0]                 wdata_i,
   input  wire logic                       last_i,
   // user result port
   output logic                            done_o,
   output logic [7:0]                      rdata_o,
   output logic                            nack_o,
   output logic                            busy_o,
   // local clock wire, open drain
   input  wire logic                       local_clock_wire_i,
   output logic                            local_clock_wire_o,
   output logic                            local_clock_wire_oe_o,
   // local data wire, open drain
   input  wire logic                       local_data_wire_i,
   output logic                            local_data_wire_o,
   output logic                            local_data_wire_oe_o
);
   import i2c_ctl_pkg::*;

   // ***********************************************
   // pin synchronisers
   // ***********************************************
   logic [1:0] scl_sync_r;
   logic [1:0] sda_sync_r;
   logic [1:0] scl_sync_nxt;
   logic [1:0] sda_sync_nxt;
   logic       scl_s;
   logic       sda_s;

   always_comb begin
      scl_sync_nxt = {scl_sync_r[0], local_clock_wire_i};
      sda_sync_nxt = {sda_sync_r[0], local_data_wire_i};
   end

   always_ff @(posedge mclk_i) begin
      if (rst_i) begin
         scl_sync_r <= 2'h3; // pulled-up idle level
         sda_sync_r <= 2'h3;
      end else begin
         scl_sync_r <= scl_sync_nxt;
         sda_sync_r <= sda_sync_nxt;
      end
   end

   assign scl_s = scl_sync_r[1];
   assign sda_s = sda_sync_r[1];

   // ***********************************************
   // quarter bit time for a speed
   // ***********************************************
   function automatic logic [CNT_W-1:0] qtr_of(input speed_type sp);
      case (sp)
         SPEED_FAST: qtr_of = CNT_W'(QTR_FAST);
         SPEED_HI:   qtr_of = CNT_W'(QTR_HI);
         default:    qtr_of = CNT_W'(QTR_STD);
      endcase
   endfunction : qtr_of

   // ***********************************************
   // sequencer state
   // ***********************************************
   state_type        state_r,   state_nxt;
   logic [1:0]       phase_r,   phase_nxt;
   logic [CNT_W-1:0] cnt_r,     cnt_nxt;
   logic [CNT_W-1:0] qtr_r,     qtr_nxt;
   logic [3:0]       bit_r,     bit_nxt;
   logic [7:0]       shift_r,   shift_nxt;
   logic             rd_r,      rd_nxt;
   logic             last_r,    last_nxt;
   logic             scl_low_r, scl_low_nxt;
   logic             sda_low_r, sda_low_nxt;
   logic             done_r,    done_nxt;
   logic [7:0]       rdata_r,   rdata_nxt;
   logic             nack_r,    nack_nxt;
   logic             tick;

   assign tick = (cnt_r == '0);

   always_comb begin
      state_nxt   = state_r;
      phase_nxt   = phase_r;
      cnt_nxt     = tick ? cnt_r : cnt_r - CNT_W'(1);
      qtr_nxt     = qtr_r;
      bit_nxt     = bit_r;
      shift_nxt   = shift_r;
      rd_nxt      = rd_r;
      last_nxt    = last_r;
      scl_low_nxt = scl_low_r;
      sda_low_nxt = sda_low_r;
      done_nxt    = 1'b0;
      rdata_nxt   = rdata_r;
      nack_nxt    = nack_r;
      case (state_r)
         ST_IDLE: begin
            scl_low_nxt = 1'b0;
            sda_low_nxt = 1'b0;
            if (cmd_valid_i) begin
               if (cmd_i == CMD_START) begin
                  state_nxt = ST_START;
                  phase_nxt = PH_FIRST;
                  qtr_nxt   = qtr_of(speed_i);
                  cnt_nxt   = qtr_of(speed_i);
                  shift_nxt = {addr_i, dir_i};
               end else begin
                  // no bus owned: command dropped, flagged
                  done_nxt = 1'b1;
                  nack_nxt = 1'b1;
               end
            end
         end
         ST_HOLD: begin
            // clock kept low between bytes
            if (cmd_valid_i) begin
               phase_nxt = PH_FIRST;
               cnt_nxt   = qtr_r;
               bit_nxt   = '0;
               case (cmd_i)
                  CMD_START: begin
                     state_nxt = ST_START;
                     shift_nxt = {addr_i, dir_i};
                  end
                  CMD_WRITE: begin
                     state_nxt = ST_BYTE;
                     rd_nxt    = 1'b0;
                     shift_nxt = wdata_i;
                  end
                  CMD_READ: begin
                     state_nxt = ST_BYTE;
                     rd_nxt    = 1'b1;
                     last_nxt  = last_i;
                  end
                  default: begin
                     state_nxt = ST_STOP;
                  end
               endcase
            end
         end
         ST_START: begin
            case (phase_r)
               PH_FIRST: begin
                  sda_low_nxt = 1'b0;
                  if (tick) begin
                     phase_nxt   = PH_MID;
                     scl_low_nxt = 1'b0;
                     cnt_nxt     = qtr_r;
                  end
               end
               PH_MID: begin
                  // wait for the clock seen high through the repeater
                  if (!scl_s) begin
                     cnt_nxt = qtr_r;
                  end else if (tick) begin
                     phase_nxt   = PH_LAST;
                     sda_low_nxt = 1'b1;
                     cnt_nxt     = qtr_r;
                  end
               end
               default: begin
                  if (tick) begin
                     scl_low_nxt = 1'b1;
                     state_nxt   = ST_BYTE;
                     phase_nxt   = PH_FIRST;
                     bit_nxt     = '0;
                     rd_nxt      = 1'b0;
                     cnt_nxt     = qtr_r;
                  end
               end
            endcase
         end
         ST_BYTE: begin
            case (phase_r)
               PH_FIRST: begin
                  if (tick) begin
                     // data moves only while the clock is low
                     if (bit_r == ACK_BIT) begin
                        sda_low_nxt = rd_r & ~last_r;
                     end else begin
                        sda_low_nxt = ~rd_r & ~shift_r[7];
                     end
                     phase_nxt = PH_MID;
                     cnt_nxt   = qtr_r;
                  end
               end
               PH_MID: begin
                  if (tick) begin
                     scl_low_nxt = 1'b0;
                     phase_nxt   = PH_LAST;
                     cnt_nxt     = qtr_r;
                  end
               end
               default: begin
                  if (!scl_s) begin
                     cnt_nxt = qtr_r;
                  end else if (tick) begin
                     scl_low_nxt = 1'b1;
                     phase_nxt   = PH_FIRST;
                     cnt_nxt     = qtr_r;
                     if (bit_r == ACK_BIT) begin
                        if (!rd_r) begin
                           nack_nxt = sda_s;
                        end else begin
                           nack_nxt = last_r;
                        end
                        rdata_nxt = shift_r;
                        done_nxt  = 1'b1;
                        state_nxt = ST_HOLD;
                     end else begin
                        shift_nxt = {shift_r[6:0], sda_s};
                        bit_nxt   = bit_r + 4'h1;
                     end
                  end
               end
            endcase
         end
         ST_STOP: begin
            case (phase_r)
               PH_FIRST: begin
                  sda_low_nxt = 1'b1;
                  if (tick) begin
                     scl_low_nxt = 1'b0;
                     phase_nxt   = PH_MID;
                     cnt_nxt     = qtr_r;
                  end
               end
               PH_MID: begin
                  if (!scl_s) begin
                     cnt_nxt = qtr_r;
                  end else if (tick) begin
                     sda_low_nxt = 1'b0;
                     phase_nxt   = PH_LAST;
                     cnt_nxt     = qtr_r;
                  end
               end
               default: begin
                  if (tick) begin
                     state_nxt = ST_IDLE;
                     done_nxt  = 1'b1;
                     nack_nxt  = 1'b0;
                  end
               end
            endcase
         end
         default: begin
            state_nxt   = ST_IDLE;
            scl_low_nxt = 1'b0;
            sda_low_nxt = 1'b0;
         end
      endcase
   end

   always_ff @(posedge mclk_i) begin
      if (rst_i) begin
         state_r   <= ST_IDLE;
         phase_r   <= PH_FIRST;
         cnt_r     <= '0;
         qtr_r     <= CNT_W'(QTR_STD);
         bit_r     <= '0;
         shift_r   <= '0;
         rd_r      <= 1'b0;
         last_r    <= 1'b0;
         scl_low_r <= 1'b0;
         sda_low_r <= 1'b0;
         done_r    <= 1'b0;
         rdata_r   <= '0;
         nack_r    <= 1'b0;
      end else begin
         state_r   <= state_nxt;
         phase_r   <= phase_nxt;
         cnt_r     <= cnt_nxt;
         qtr_r     <= qtr_nxt;
         bit_r     <= bit_nxt;
         shift_r   <= shift_nxt;
         rd_r      <= rd_nxt;
         last_r    <= last_nxt;
         scl_low_r <= scl_low_nxt;
         sda_low_r <= sda_low_nxt;
         done_r    <= done_nxt;
         rdata_r   <= rdata_nxt;
         nack_r    <= nack_nxt;
      end
   end

   // ***********************************************
   // outputs
   // ***********************************************
   // open drain: drive low or release, never high
   assign local_clock_wire_o    = 1'b0;
   assign local_clock_wire_oe_o = scl_low_r; // single node
   assign local_data_wire_o     = 1'b0;
   assign local_data_wire_oe_o  = sda_low_r;
   assign cmd_ready_o = (state_r == ST_IDLE) || (state_r == ST_HOLD);
   assign busy_o      = (state_r != ST_IDLE);
   assign done_o      = done_r;
   assign rdata_o     = rdata_r;
   assign nack_o      = nack_r;

endmodule : i2c_side1_ctl

// ---- tb/i2c_side1_ctl_properties.sv ----
// concurrent checks on the side-1 controller ports
`timescale 1ns/1ns
module i2c_side1_ctl_properties (
   // clock and reset
   input wire logic                 mclk_i,
   input wire logic                 rst_i,
   // command side
   input wire logic                 cmd_valid_i,
   input wire logic                 cmd_ready_o,
   input wire i2c_ctl_pkg::cmd_type cmd_i,
   input wire logic                 done_o,
   input wire logic                 nack_o,
   input wire logic                 busy_o,
   // local wires
   input wire logic                 local_clock_wire_i,
   input wire logic                 local_clock_wire_o,
   input wire logic                 local_clock_wire_oe_o,
   input wire logic                 local_data_wire_o,
   input wire logic                 local_data_wire_oe_o
);
   import i2c_ctl_pkg::*;
   // ****************
   // properties
   // ****************
   default clocking cb @(posedge mclk_i); endclocking
   default disable iff (rst_i);
   sequence s_idle_take;
      cmd_valid_i && cmd_ready_o && !busy_o;
   endsequence
   sequence s_low_seen;
      !local_clock_wire_oe_o && !local_clock_wire_i
         ##1 !local_clock_wire_oe_o;
   endsequence
   property p_open_drain;
      !local_clock_wire_o && !local_data_wire_o;
   endproperty
   a_open_drain: assert property (p_open_drain)
      else $error("wire driven high");
   property p_idle;
      !busy_o |-> cmd_ready_o && !local_clock_wire_oe_o
         && !local_data_wire_oe_o;
   endproperty
   a_idle: assert property (p_idle)
      else $error("idle not quiet");
   property p_refuse;
      s_idle_take ##0 cmd_i != CMD_START |=> done_o ##1 nack_o;
   endproperty
   a_refuse: assert property (p_refuse)
      else $error("command not refused");
   property p_start;
      s_idle_take ##0 cmd_i == CMD_START |=> (busy_o && !done_o) [*8];
   endproperty
   a_start: assert property (p_start)
      else $error("start not begun");
   property p_done_pulse;
      done_o |=> !done_o;
   endproperty
   a_done_pulse: assert property (p_done_pulse)
      else $error("done longer than one cycle");
   property p_wait_high;
      s_low_seen |=> !local_clock_wire_oe_o;
   endproperty
   a_wait_high: assert property (p_wait_high)
      else $error("clock pulled while held low");
   property p_pull_high;
      $rose(local_clock_wire_oe_o) |-> $past(local_clock_wire_i, 2);
   endproperty
   a_pull_high: assert property (p_pull_high)
      else $error("clock high phase skipped");
   property p_stop;
      $fell(local_data_wire_oe_o) && !local_clock_wire_oe_o
         |-> ##[1:300] done_o && !nack_o;
   endproperty
   a_stop: assert property (p_stop)
      else $error("stop not completed");
   property p_start_cond;
      $rose(local_data_wire_oe_o) && !local_clock_wire_oe_o
         |-> ##[1:300] $rose(local_clock_wire_oe_o);
   endproperty
   a_start_cond: assert property (p_start_cond)
      else $error("start not followed by clock");
endmodule : i2c_side1_ctl_properties
bind i2c_side1_ctl i2c_side1_ctl_properties u_props (
   .mclk_i(mclk_i), .rst_i(rst_i), .cmd_valid_i(cmd_valid_i),
   .cmd_ready_o(cmd_ready_o), .cmd_i(cmd_i), .done_o(done_o),
   .nack_o(nack_o), .busy_o(busy_o),
   .local_clock_wire_i(local_clock_wire_i),
   .local_clock_wire_o(local_clock_wire_o),
   .local_clock_wire_oe_o(local_clock_wire_oe_o),
   .local_data_wire_o(local_data_wire_o),
   .local_data_wire_oe_o(local_data_wire_oe_o));

// ---- tb/i2c_bus_target_model.sv ----
// repeater and side-2 target seen from the local wires
`timescale 1ns/1ns
module i2c_bus_target_model #(
   parameter logic [6:0] TARGET_ADDR = 7'h5a
) (
   // link clock
   input  wire logic link_clk_i,
   // wire levels, stretch enable and power enable
   input  wire logic scl_i,
   input  wire logic sda_i,
   input  wire logic stretch_i,
   input  wire logic powered_i,
   // pull-low requests
   output logic      scl_low_o,
   output logic      sda_low_o
);
   logic [7:0] sh  = 8'h00;
   logic [7:0] mem = 8'h00;
   logic       ps  = 1'b1;
   logic       pd  = 1'b1;
   logic       fst = 1'b0;
   logic       rd  = 1'b0;
   logic       sel = 1'b0;
   int         bc  = 0;
   int         cnt = 0;
   initial sda_low_o = 1'b0;
   initial scl_low_o = 1'b0;
   // ****************
   // sampled wire events, one link cycle late
   // ****************
   always @(posedge link_clk_i) begin
      if (ps && scl_i && pd && !sda_i) begin // start
         bc = 0;
         fst = 1'b1;
         rd = 1'b0;
         sel = 1'b0;
      end else if (!ps && scl_i && bc < 9) begin
         if (bc < 8)
            sh = {sh[6:0], sda_i}; // msb first
         else if (rd && sda_i)
            sel = 1'b0; // reader gave no ack
         bc = bc + 1;
      end else if (ps && !scl_i) begin
         if (bc == 8) begin
            if (fst) begin
               sel = (sh[7:1] == TARGET_ADDR);
               rd = sh[0];
            end else if (!rd)
               mem = sh;
            sda_low_o = sel && (fst || !rd); // ack
            fst = 1'b0;
            cnt = stretch_i ? 12 : 0;
         end else begin
            if (bc == 9)
               bc = 0;
            sda_low_o = sel && rd && !mem[7 - bc];
         end
      end
      if (cnt > 0)
         cnt = cnt - 1;
      scl_low_o = (cnt != 0);
      if (!powered_i) begin
         scl_low_o = 1'b0; // undervoltage floats
         sda_low_o = 1'b0;
      end
      ps = scl_i;
      pd = sda_i;
   end
endmodule : i2c_bus_target_model

// ---- tb/tb.sv ----
// self-checking bench for the side-1 bus controller
`timescale 1ns/1ns
module tb;
   import i2c_ctl_pkg::*;
   logic       mclk_i      = 1'b0;
   logic       link_clk    = 1'b0;
   logic       rst_i       = 1'b1;
   logic       cmd_valid_i = 1'b0;
   cmd_type    cmd_i       = CMD_START;
   speed_type  speed_i     = SPEED_STD;
   logic [6:0] addr_i      = 7'h5a;
   logic       dir_i       = 1'b0;
   logic [7:0] wdata_i     = 8'h00;
   logic       last_i      = 1'b0;
   logic       stretch     = 1'b0;
   logic       powered     = 1'b1;
   logic       cmd_ready_o, done_o, nack_o, busy_o;
   logic [7:0] rdata_o;
   logic       scl_o, scl_oe, sda_o, sda_oe, scl_low, sda_low;
   wire        scl = ~((scl_oe & ~scl_o) | scl_low);
   wire        sda = ~((sda_oe & ~sda_o) | sda_low);
   int         fail_count = 0;
   int         compares   = 0;
   int         cycles     = 0;
   int         qtr [3]    = '{QTR_STD, QTR_FAST, QTR_HI};
   always #5 mclk_i = ~mclk_i;
   always #24 link_clk = ~link_clk;
   i2c_side1_ctl DUT (
      .mclk_i(mclk_i), .rst_i(rst_i), .cmd_valid_i(cmd_valid_i),
      .cmd_ready_o(cmd_ready_o), .cmd_i(cmd_i), .speed_i(speed_i),
      .addr_i(addr_i), .dir_i(dir_i), .wdata_i(wdata_i), .last_i(last_i),
      .done_o(done_o), .rdata_o(rdata_o), .nack_o(nack_o), .busy_o(busy_o),
      .local_clock_wire_i(scl), .local_clock_wire_o(scl_o),
      .local_clock_wire_oe_o(scl_oe), .local_data_wire_i(sda),
      .local_data_wire_o(sda_o), .local_data_wire_oe_o(sda_oe));
   i2c_bus_target_model #(.TARGET_ADDR(7'h5a)) partner (
      .link_clk_i(link_clk), .scl_i(scl), .sda_i(sda),
      .stretch_i(stretch), .powered_i(powered), .scl_low_o(scl_low),
      .sda_low_o(sda_low));
   // ****************
   // shared tasks
   // ****************
   task automatic check(input logic [7:0] got, input logic [7:0] exp);
      compares++;
      if (got !== exp) begin
         fail_count++;
         $display("MISMATCH at %0t got %h expected %h", $time, got, exp);
      end
   endtask : check
   task automatic test_done;
      $display("compares %0d fail_count %0d", compares, fail_count);
      if (fail_count == 0 && compares > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask : test_done
   task automatic send(input cmd_type c, input logic [7:0] w,
                       input logic l);
      check(cmd_ready_o, 1'b1);
      cmd_i = c;
      wdata_i = w;
      last_i = l;
      cmd_valid_i = 1'b1;
      @(posedge mclk_i);
      #1;
      cmd_valid_i = 1'b0;
      cycles = 0;
      while (done_o !== 1'b1) begin
         @(posedge mclk_i);
         #1;
         cycles++;
         if (cycles > 40000) begin
            fail_count++;
            test_done();
         end
      end
      @(posedge mclk_i);
      #1;
   endtask : send
   // ****************
   // scenarios
   // ****************
   task automatic t_refuse;
      for (int c = 1; c < 4; c++) begin
         send(cmd_type'(c), 8'h00, 1'b0);
         check(nack_o, 1'b1);
         check({6'h00, scl, sda}, 8'h03);
      end
      $display("test refuse done");
   endtask : t_refuse
   task automatic t_write(input int s, input logic [7:0] w);
      logic ok;
      speed_i = speed_type'(s);
      dir_i = DIR_WRITE;
      send(CMD_START, 8'h00, 1'b0);
      check(nack_o, 1'b0);
      send(CMD_WRITE, w, 1'b0);
      ok = cycles >= 27 * qtr[s] - 2 && cycles < 27 * qtr[s] + 150;
      check(ok, 1'b1);
      check(nack_o, 1'b0);
      check(rdata_o, w);
      send(CMD_STOP, 8'h00, 1'b0);
      check(nack_o, 1'b0);
      check({6'h00, scl, sda}, 8'h03);
      $display("test write at speed %0d done", s);
   endtask : t_write
   task automatic t_read;
      stretch = 1'b1;
      speed_i = SPEED_HI;
      dir_i = DIR_WRITE;
      send(CMD_START, 8'h00, 1'b0);
      send(CMD_WRITE, 8'h96, 1'b0);
      dir_i = DIR_READ;
      send(CMD_START, 8'h00, 1'b0);
      check(nack_o, 1'b0);
      send(CMD_READ, 8'h00, 1'b0);
      check(rdata_o, 8'h96);
      check(nack_o, 1'b0);
      send(CMD_READ, 8'h00, 1'b1);
      check(rdata_o, 8'h96);
      check(nack_o, 1'b1);
      send(CMD_STOP, 8'h00, 1'b0);
      check(nack_o, 1'b0);
      stretch = 1'b0;
      $display("test read done");
   endtask : t_read
   task automatic t_noaddr;
      addr_i = 7'h2d;
      dir_i = DIR_WRITE;
      send(CMD_START, 8'h00, 1'b0);
      check(nack_o, 1'b1);
      send(CMD_STOP, 8'h00, 1'b0);
      check(busy_o, 1'b0);
      addr_i = 7'h5a;
      powered = 1'b0;
      send(CMD_START, 8'h00, 1'b0);
      check(nack_o, 1'b1);
      send(CMD_STOP, 8'h00, 1'b0);
      check({6'h00, scl, sda}, 8'h03);
      powered = 1'b1;
      $display("test no target done");
   endtask : t_noaddr
   initial begin
      repeat (16) @(posedge mclk_i);
      #1;
      rst_i = 1'b0;
      t_refuse();
      for (int s = 0; s < 3; s++)
         t_write(s, 8'h3c ^ 8'(s));
      t_read();
      t_noaddr();
      test_done();
   end
endmodule : tb
